// >>> rcs_regs.sv
// Purpose: retry limits, compare-swap on bus resources, rom header
// Assumes: one clock, synchronous reset, wishbone classic master
// Notes: ack comes one cycle after the request is seen
`timescale 1ns/1ps
`default_nettype none
module rcs_regs
   import rcs_pkg::*;
(
   input wire logic clk_i, // system clock
   input wire logic rst_i, // sync reset, high
   input wire logic ce_i, // clock enable
   input wire logic wb_cyc_i, // bus cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write enable
   input wire logic [RCS_AW-1:0] wb_adr_i, // byte address
   input wire logic [RCS_SW-1:0] wb_sel_i, // byte lanes
   input wire logic [RCS_DW-1:0] wb_dat_i, // write data
   output logic [RCS_DW-1:0] wb_dat_o, // read data
   output logic wb_ack_o, // acknowledge
   output logic irq_o, // level interrupt
   output logic [RCS_RTY_W-1:0] physical_response_retry_count_o, // limit
   output logic [RCS_RTY_W-1:0] async_response_retry_count_o, // limit
   output logic [RCS_RTY_W-1:0] async_request_retry_count_o, // limit
   output logic [RCS_DW-1:0] rom_header_o, // remote quadlet
   output logic swap_busy_o // swap in flight
);

   function automatic logic [RCS_DW-1:0] lane_merge(
      input logic [RCS_DW-1:0] old_v,
      input logic [RCS_DW-1:0] new_v,
      input logic [RCS_SW-1:0] sel_v
   );
      logic [RCS_DW-1:0] r;
      r = old_v;
      for (int i = 0; i < RCS_SW; i++)
      begin
         if (sel_v[i])
         begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic reg_hit(
      input logic [RCS_AW-1:0] adr,
      input logic [RCS_AW-1:0] off
   );
      return adr[RCS_AW-1:2] == off[RCS_AW-1:2];
   endfunction

   logic ack_q;
   logic [RCS_DW-1:0] dat_q;
   logic [RCS_RTY_BITS-1:0] retry_q;
   logic [RCS_DW-1:0] data_q;
   logic [RCS_DW-1:0] cmp_q;
   logic done_q;
   logic [RCS_SEL_W-1:0] sel_q;
   logic [RCS_DW-1:0] rom_q;
   logic [RCS_EV_W-1:0] stat_q;
   logic [RCS_EV_W-1:0] stat_d;
   logic [RCS_EV_W-1:0] mask_q;
   logic irq_q;
   logic busy_q;
   logic [RCS_DW-1:0] res_q [RCS_NRES];
   rcs_state_t st_q;
   rcs_state_t st_d;

   wire acc_w = wb_cyc_i && wb_stb_i && !ack_q;
   wire wr_w = acc_w && wb_we_i;
   wire rd_w = acc_w && !wb_we_i;
   wire hit_retry = reg_hit(wb_adr_i, RCS_OFF_RETRY);
   wire hit_data = reg_hit(wb_adr_i, RCS_OFF_DATA);
   wire hit_cmp = reg_hit(wb_adr_i, RCS_OFF_CMP);
   wire hit_ctl = reg_hit(wb_adr_i, RCS_OFF_CTL);
   wire hit_rom = reg_hit(wb_adr_i, RCS_OFF_ROM);
   wire hit_stat = reg_hit(wb_adr_i, RCS_OFF_STAT);
   wire hit_mask = reg_hit(wb_adr_i, RCS_OFF_MASK);
   wire wr_ctl = wr_w && hit_ctl;
   wire in_swap = st_q == RCS_SWAP;
   // resource picked by the select field
   wire [RCS_DW-1:0] cur_w = res_q[sel_q];
   wire match_w = cur_w == cmp_q;
   wire [RCS_DW-1:0] retry_new = lane_merge(
      {RCS_RTY_HI, retry_q}, wb_dat_i, wb_sel_i);
   // upper retry bits are not stored, so always read zero
   wire [RCS_DW-1:0] retry_rd = {RCS_RTY_HI, retry_q};
   wire [RCS_DW-1:0] ctl_rd = {done_q, RCS_CTL_RSV, sel_q};
   wire [RCS_DW-1:0] stat_rd = {{(RCS_DW-RCS_EV_W){1'b0}}, stat_q};
   wire [RCS_DW-1:0] mask_rd = {{(RCS_DW-RCS_EV_W){1'b0}}, mask_q};
   wire [RCS_DW-1:0] rd_mux =
      hit_retry ? retry_rd :
      hit_data ? data_q :
      hit_cmp ? cmp_q :
      hit_ctl ? ctl_rd :
      hit_rom ? rom_q :
      hit_stat ? stat_rd :
      hit_mask ? mask_rd : RCS_WORD_RST;
   wire [RCS_EV_W-1:0] ev_w = in_swap ?
      {!match_w, 1'b1} : RCS_EV_NONE;
   wire [RCS_EV_W-1:0] clr_w = (wr_w && hit_stat && wb_sel_i[0]) ?
      wb_dat_i[RCS_EV_W-1:0] : RCS_EV_NONE;

   // set wins over the write-one clear
   always_comb
   begin
      stat_d = (stat_q & ~clr_w) | ev_w;
   end

   always_comb
   begin
      st_d = st_q;
      case (st_q)
         RCS_IDLE:
         begin
            if (wr_ctl)
            begin
               st_d = RCS_SWAP;
            end
         end
         RCS_SWAP:
         begin
            st_d = RCS_IDLE;
         end
         default:
         begin
            st_d = RCS_IDLE;
         end
      endcase
   end

   // bus answer: one wait state, zero data for writes and holes
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         ack_q <= 1'b0;
         dat_q <= RCS_WORD_RST;
      end
      else if (ce_i)
      begin
         ack_q <= acc_w;
         dat_q <= rd_w ? rd_mux : RCS_WORD_RST;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         retry_q <= RCS_RTY_RST;
      end
      else if (ce_i && wr_w && hit_retry)
      begin
         retry_q <= retry_new[RCS_RTY_BITS-1:0];
      end
   end

   // data register: loaded by software, returns old value after a swap
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         data_q <= RCS_WORD_RST;
      end
      else if (ce_i && in_swap)
      begin
         data_q <= cur_w;
      end
      else if (ce_i && wr_w && hit_data)
      begin
         data_q <= lane_merge(data_q, wb_dat_i, wb_sel_i);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cmp_q <= RCS_WORD_RST;
      end
      else if (ce_i && wr_w && hit_cmp)
      begin
         cmp_q <= lane_merge(cmp_q, wb_dat_i, wb_sel_i);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         done_q <= 1'b1;
         busy_q <= 1'b0;
         sel_q <= RCS_SEL_RST;
         st_q <= RCS_IDLE;
      end
      else if (ce_i)
      begin
         st_q <= st_d;
         if (wr_ctl)
         begin
            done_q <= 1'b0;
            busy_q <= 1'b1;
            if (wb_sel_i[0])
            begin
               sel_q <= wb_dat_i[RCS_SEL_W-1:0];
            end
         end
         else if (in_swap)
         begin
            done_q <= 1'b1;
            busy_q <= 1'b0;
         end
      end
   end

   // compare and store happen in one cycle, nothing else writes them
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         for (int i = 0; i < RCS_NRES; i++)
         begin
            res_q[i] <= RCS_RES_RST;
         end
      end
      else if (ce_i && in_swap && match_w)
      begin
         res_q[sel_q] <= data_q;
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rom_q <= RCS_WORD_RST;
      end
      else if (ce_i && wr_w && hit_rom)
      begin
         rom_q <= lane_merge(rom_q, wb_dat_i, wb_sel_i);
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         stat_q <= RCS_EV_NONE;
         mask_q <= RCS_EV_NONE;
         irq_q <= 1'b0;
      end
      else if (ce_i)
      begin
         stat_q <= stat_d;
         if (wr_w && hit_mask && wb_sel_i[0])
         begin
            mask_q <= wb_dat_i[RCS_EV_W-1:0];
         end
         irq_q <= |(stat_q & mask_q);
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign irq_o = irq_q;
   assign physical_response_retry_count_o =
      retry_q[RCS_PHYS_LSB +: RCS_RTY_W];
   assign async_response_retry_count_o =
      retry_q[RCS_RESP_LSB +: RCS_RTY_W];
   assign async_request_retry_count_o =
      retry_q[RCS_REQ_LSB +: RCS_RTY_W];
   assign rom_header_o = rom_q;
   assign swap_busy_o = busy_q;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   wire rd_retry_ack = ack_q && !wb_we_i && hit_retry;
   wire rd_ctl_ack = ack_q && !wb_we_i && hit_ctl;

   sequence s_ctl_write;
      wr_ctl && ce_i;
   endsequence

   sequence s_swap_run;
      s_ctl_write ##1 ce_i;
   endsequence

   chk_dual_zero: assert property (
      rd_retry_ack |-> dat_q[31:16] == 16'h0000)
      else $error("dual-phase retry fields not zero");

   chk_retry_resv: assert property (
      rd_retry_ack |-> dat_q[15:12] == 4'h0)
      else $error("retry reserved bits not zero");

   chk_retry_write: assert property (
      (wr_w && hit_retry && ce_i && wb_sel_i == 4'hF) |=>
      {physical_response_retry_count_o, async_response_retry_count_o,
       async_request_retry_count_o} == $past(wb_dat_i[11:0]))
      else $error("retry counts not stored");

   chk_done_clear: assert property (
      s_ctl_write |=> !done_q && swap_busy_o)
      else $error("complete flag not cleared by write");

   chk_done_set: assert property (
      s_swap_run |=> done_q && !swap_busy_o)
      else $error("complete flag not set after swap");

   chk_swap_store: assert property (
      (in_swap && ce_i && match_w) |=>
      res_q[$past(sel_q)] == $past(data_q))
      else $error("matching swap did not store data");

   chk_swap_keep: assert property (
      (in_swap && ce_i && !match_w) |=>
      res_q[$past(sel_q)] == $past(cur_w))
      else $error("mismatching swap changed resource");

   chk_old_return: assert property (
      (in_swap && ce_i) |=> data_q == $past(cur_w) ##1 !in_swap)
      else $error("old resource value not returned");

   chk_ctl_read: assert property (
      rd_ctl_ack |-> dat_q[30:2] == 29'h00000000)
      else $error("control reserved bits not zero");

   chk_reset_done: assert property (
      $past(rst_i) |-> done_q && st_q == RCS_IDLE)
      else $error("complete flag not set by reset");

   chk_rom_write: assert property (
      (wr_w && hit_rom && ce_i && wb_sel_i == 4'hF) |=>
      rom_header_o == $past(wb_dat_i))
      else $error("rom header not written");

   chk_irq_level: assert property (
      ce_i |=> irq_o == |($past(stat_q) & $past(mask_q)))
      else $error("interrupt level wrong");

   chk_ack_single: assert property (
      (ack_q && ce_i) |=> !ack_q)
      else $error("acknowledge held longer than one cycle");

   chk_sel_store: assert property (
      (wr_ctl && ce_i && wb_sel_i[0]) |=> sel_q == $past(wb_dat_i[RCS_SEL_W-1:0]))
      else $error("resource select not stored");

   chk_event_set: assert property (
      (in_swap && ce_i) |=> stat_q[RCS_EV_DONE])
      else $error("swap finished event not recorded");

   chk_busy_flag: assert property (
      swap_busy_o == !done_q)
      else $error("busy output disagrees with complete flag");

endmodule
`default_nettype wire

// >>> rcs_pkg.sv
// Purpose: constants and types for the retry and compare-swap register bank
// Assumes: 32-bit classic wishbone, byte addresses on the bus
// Notes: offsets are byte addresses, each register one aligned word
package rcs_pkg;
   localparam int RCS_DW = 32;
   localparam int RCS_AW = 8;
   localparam int RCS_SW = 4;
   // register offsets
   localparam logic [7:0] RCS_OFF_RETRY = 8'h08;
   localparam logic [7:0] RCS_OFF_DATA = 8'h0C;
   localparam logic [7:0] RCS_OFF_CMP = 8'h10;
   localparam logic [7:0] RCS_OFF_CTL = 8'h14;
   localparam logic [7:0] RCS_OFF_ROM = 8'h18;
   localparam logic [7:0] RCS_OFF_STAT = 8'h24;
   localparam logic [7:0] RCS_OFF_MASK = 8'h28;
   // retry register fields
   localparam int RCS_RTY_W = 4;
   localparam int RCS_RTY_BITS = 12;
   localparam int RCS_PHYS_LSB = 8;
   localparam int RCS_RESP_LSB = 4;
   localparam int RCS_REQ_LSB = 0;
   localparam logic [19:0] RCS_RTY_HI = 20'h00000;
   localparam logic [11:0] RCS_RTY_RST = 12'h000;
   // swap control fields
   localparam int RCS_DONE_BIT = 31;
   localparam int RCS_SEL_W = 2;
   localparam logic [28:0] RCS_CTL_RSV = 29'h00000000;
   localparam logic [1:0] RCS_SEL_RST = 2'h0;
   // resource select codes
   localparam logic [1:0] RCS_RES_BM_ID = 2'h0;
   localparam logic [1:0] RCS_RES_BW_AVAIL = 2'h1;
   localparam logic [1:0] RCS_RES_CH_HI = 2'h2;
   localparam logic [1:0] RCS_RES_CH_LO = 2'h3;
   localparam int RCS_NRES = 4;
   // reset values
   localparam logic [31:0] RCS_WORD_RST = 32'h00000000;
   localparam logic [31:0] RCS_RES_RST = 32'h00000000;
   // interrupt event bits
   localparam int RCS_EV_W = 2;
   localparam int RCS_EV_DONE = 0;
   localparam int RCS_EV_MISS = 1;
   localparam logic [1:0] RCS_EV_NONE = 2'h0;
   typedef enum logic [1:0]
   {
      RCS_IDLE = 2'b01,
      RCS_SWAP = 2'b10
   } rcs_state_t;
endpackage

// >>> rcs_regs_tb.sv
// Purpose: self-checking bench for the retry and compare-swap register bank
// Assumes: classic wishbone master, ack one cycle after the request is taken
// Notes: resources are seen only through the data register after a swap
`timescale 1ns/1ps
`default_nettype none
module rcs_regs_tb
   import rcs_pkg::*;
;
   logic clk_i;
   logic rst_i;
   logic ce_i;
   logic cyc;
   logic stb;
   logic we;
   logic [RCS_AW-1:0] adr;
   logic [RCS_SW-1:0] sel;
   logic [RCS_DW-1:0] wdat;
   logic [RCS_DW-1:0] rdat;
   logic ack;
   logic irq;
   logic [RCS_RTY_W-1:0] phys_cnt;
   logic [RCS_RTY_W-1:0] resp_cnt;
   logic [RCS_RTY_W-1:0] req_cnt;
   logic [RCS_DW-1:0] rom_hdr;
   logic busy;
   int n_busy = 0;
   int n_mismatch;
   int n_checks;

   rcs_regs u_dut (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ce_i(ce_i),
      .wb_cyc_i(cyc),
      .wb_stb_i(stb),
      .wb_we_i(we),
      .wb_adr_i(adr),
      .wb_sel_i(sel),
      .wb_dat_i(wdat),
      .wb_dat_o(rdat),
      .wb_ack_o(ack),
      .irq_o(irq),
      .physical_response_retry_count_o(phys_cnt),
      .async_response_retry_count_o(resp_cnt),
      .async_request_retry_count_o(req_cnt),
      .rom_header_o(rom_hdr),
      .swap_busy_o(busy)
   );

   initial
   begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // counts edges at which the complete flag was seen clear
   always @(posedge clk_i)
   begin
      if (busy === 1'b1)
         n_busy <= n_busy + 1;
   end

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t word got %h want %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      n_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD %0t bit got %b want %b", $time, got, exp);
      end
   endtask

   // one classic cycle; read data is taken at the edge that sees ack
   task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      q = rdat;
      if (n >= 20)
      begin
         n_mismatch++;
         $display("BAD %0t no ack", $time);
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb_cycle(1'b1, a, d, 4'hF, q);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb_cycle(1'b0, a, 32'h00000000, 4'hF, q);
      chk32(q, exp);
   endtask

   task automatic test_reset();
      rd_chk(RCS_OFF_RETRY, 32'h00000000);
      rd_chk(RCS_OFF_CTL, 32'h80000000);
      rd_chk(RCS_OFF_ROM, 32'h00000000);
      chk1(busy, 1'b0);
      chk1(irq, 1'b0);
   endtask

   task automatic test_retry();
      wr(RCS_OFF_RETRY, 32'hFFFFFFFF);
      rd_chk(RCS_OFF_RETRY, 32'h00000FFF);
      wr(RCS_OFF_RETRY, 32'hE000A5C3);
      rd_chk(RCS_OFF_RETRY, 32'h000005C3);
      chk32({28'h0000000, phys_cnt}, 32'h00000005);
      chk32({28'h0000000, resp_cnt}, 32'h0000000C);
      chk32({28'h0000000, req_cnt}, 32'h00000003);
   endtask

   task automatic test_rom();
      wr(RCS_OFF_ROM, 32'h0412C0DE);
      rd_chk(RCS_OFF_ROM, 32'h0412C0DE);
      chk32(rom_hdr, 32'h0412C0DE);
   endtask

   // one compare-swap; the data register must return the resource's old value
   task automatic do_swap(input logic [1:0] s, input logic [31:0] d, input logic [31:0] c,
                          input logic [31:0] old);
      int b0;
      wr(RCS_OFF_DATA, d);
      wr(RCS_OFF_CMP, c);
      b0 = n_busy;
      wr(RCS_OFF_CTL, {30'h00000000, s});
      rd_chk(RCS_OFF_CTL, {1'b1, 29'h00000000, s});
      chk1(n_busy > b0, 1'b1);
      rd_chk(RCS_OFF_DATA, old);
   endtask

   task automatic test_swap();
      for (int i = 0; i < RCS_NRES; i++)
         do_swap(i[1:0], 32'hA0000000 | i, 32'h00000000, 32'h00000000);
      rd_chk(RCS_OFF_STAT, 32'h00000001);
      for (int i = 0; i < RCS_NRES; i++)
         do_swap(i[1:0], 32'h55555555, 32'h00000000, 32'hA0000000 | i);
      for (int i = 0; i < RCS_NRES; i++)
         do_swap(i[1:0], 32'h00000000, 32'hA0000000 | i, 32'hA0000000 | i);
      wr(RCS_OFF_CTL, 32'h7FFFFFFD);
      rd_chk(RCS_OFF_CTL, 32'h80000001);
   endtask

   task automatic test_irq();
      rd_chk(RCS_OFF_STAT, 32'h00000003);
      chk1(irq, 1'b0);
      wr(RCS_OFF_MASK, 32'h00000002);
      rd_chk(RCS_OFF_MASK, 32'h00000002);
      repeat (2) @(posedge clk_i);
      chk1(irq, 1'b1);
      wr(RCS_OFF_STAT, 32'h00000002);
      repeat (2) @(posedge clk_i);
      chk1(irq, 1'b0);
      rd_chk(RCS_OFF_STAT, 32'h00000001);
      wr(RCS_OFF_MASK, 32'h00000003);
      repeat (2) @(posedge clk_i);
      chk1(irq, 1'b1);
      wr(RCS_OFF_STAT, 32'h00000001);
      repeat (2) @(posedge clk_i);
      chk1(irq, 1'b0);
      // unmapped place reads zero and ignores writes
      wr(8'h30, 32'hFFFFFFFF);
      rd_chk(8'h30, 32'h00000000);
   endtask

   // clock enable low freezes the bus answer and every register
   task automatic test_hold();
      int n;
      @(posedge clk_i);
      ce_i <= 1'b0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= 1'b1;
      adr <= RCS_OFF_ROM;
      sel <= 4'hF;
      wdat <= 32'h12345678;
      repeat (3) @(posedge clk_i);
      chk1(ack, 1'b0);
      chk32(rom_hdr, 32'h0412C0DE);
      ce_i <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      chk1(ack, 1'b1);
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      rd_chk(RCS_OFF_ROM, 32'h12345678);
      chk32(rom_hdr, 32'h12345678);
   endtask

   initial
   begin
      #100000;
      n_mismatch++;
      $display("BAD %0t watchdog expired", $time);
      end_of_test();
   end

   initial
   begin
      n_mismatch = 0;
      n_checks = 0;
      rst_i = 1'b1;
      ce_i = 1'b1;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      adr = 8'h00;
      sel = 4'h0;
      wdat = 32'h00000000;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      test_reset();
      test_retry();
      test_rom();
      test_swap();
      test_irq();
      test_hold();
      end_of_test();
   end
endmodule
`default_nettype wire
